// ===== hdl/mbre_pkg.sv
// Shared constants and types for the multiprocessor boot role election.
// Assumes a single 125 MHz clock shared by both ends of the link.
package mbre_pkg;
    // Register byte addresses in the memory-mapped controller window.
    localparam logic [31:0] IDENT_OFF = 32'hfee00020;
    localparam logic [31:0] SVR_OFF = 32'hfee000f0;
    localparam logic [31:0] CMD_OFF = 32'hfee00300;
    localparam logic [31:0] ERRV_OFF = 32'hfee00370;
    localparam logic [31:0] STAT_OFF = 32'hfee003f0;
    // Field positions, masks and reset values.
    localparam int SVR_EN_BIT = 8;
    localparam logic [31:0] SVR_RST = 32'h00000000;
    localparam logic [31:0] ERRV_RST = 32'h00000000;
    localparam logic [31:0] ERRV_KEEP = 32'hffffff00;
    localparam logic [31:0] IDENT_MASK = 32'hff000000;
    localparam int IDENT_TOP = 24;
    // Command encodings and addresses.
    localparam logic [31:0] CMD_REINIT = 32'h000c4500;
    localparam logic [23:0] CMD_SU_HI = 24'h000c46;
    localparam logic [31:0] RESET_VEC = 32'hfffffff0;
    localparam logic [7:0] SEM_FREE = 8'h00;
    localparam logic [7:0] SEM_TAKEN = 8'h01;
    localparam logic [7:0] COUNT_INIT = 8'h01;
    // Timing, in printed units, and the derived cycle counts.
    localparam int CLK_MHZ = 125;
    localparam int T_REINIT_MS = 10;
    localparam int T_STARTUP_US = 200;
    localparam int T_COUNT_MS = 100;
    localparam int CNT_W = 24;
    localparam int REINIT_CYC = T_REINIT_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_CYC = T_STARTUP_US * CLK_MHZ;
    localparam int COUNT_CYC = T_COUNT_MS * 1000 * CLK_MHZ;
    // Messages other than startup that reach a core, reinit among them.
    typedef enum logic [2:0] {
        MSG_NONE = 3'b000,
        MSG_NMI = 3'b001,
        MSG_SMI = 3'b010,
        MSG_FIXED = 3'b011,
        MSG_SNOOP = 3'b100,
        MSG_REINIT = 3'b101
    } mbre_msg_e;
endpackage

// ===== hdl/mbre_link_if.sv
// Link between one processor core's boot logic and the waking peer, which
// also stands for the shared bus. Both ends run on the same clock.
`timescale 1ns/1ps
interface mbre_link_if;
    import mbre_pkg::*;
    logic bnr;
    logic spc_req;
    logic [7:0] spc_prio;
    logic spc_ack;
    logic spc_won;
    logic claim_req;
    logic claim_ack;
    logic claim_won;
    logic final_req;
    logic final_rx;
    logic cmd_valid;
    logic [31:0] cmd_word;
    logic evt_valid;
    mbre_msg_e evt_kind;
    logic stop_clk;
    logic sem_req;
    logic sem_gnt;
    logic sem_rel;
    logic cnt_inc;
    logic [31:0] mgmt_base;
    logic dev_cmd_valid;
    logic [31:0] dev_cmd_word;
    modport core (
        input bnr, spc_ack, spc_won, claim_ack, claim_won, final_rx, cmd_valid, cmd_word,
        input evt_valid, evt_kind, stop_clk, sem_gnt,
        output spc_req, spc_prio, claim_req, final_req, sem_req, sem_rel, cnt_inc,
        output mgmt_base, dev_cmd_valid, dev_cmd_word
    );
    modport waker (
        output bnr, spc_ack, spc_won, claim_ack, claim_won, final_rx, cmd_valid, cmd_word,
        output evt_valid, evt_kind, stop_clk, sem_gnt,
        input spc_req, spc_prio, claim_req, final_req, sem_req, sem_rel, cnt_inc,
        input mgmt_base, dev_cmd_valid, dev_cmd_word
    );
endinterface

// ===== hdl/mbre_core.sv
// Boot role election and local controller registers of one logical core.
// Assumes the waker on the link answers requests one cycle later and that
// the bus-not-ready pin arrives unsynchronised.
//
// Contract
// [R01] Unique identifier, 32 or 8 bits, loaded.
// [R02] Arbitration priority derived from the identifier.
// [R03] Election starts only after self test.
// [R04] New revision: special cycle after pin quiet.
// [R05] Special-cycle winner leads, fetches reset vector.
// [R06] Losers clear leader flag, await startup.
// [R07] Old revision: first own claim wins.
// [R08] Old revision: final message starts leader fetch.
// [R09] Startup fetch address is 000VV000H.
// [R10] Followers take semaphore, count in, halt.
// [R11] Halted follower takes only listed events.
// [R12] Controller enabled by spurious bit 8.
// [R13] Error entry low byte holds vector.
// [R14] Reinit and startup command encodings broadcast.
// [R15] Waker: reinit, 10 ms, startup twice, 200 us.
// [R16] Waker: count one, 100 ms timer check.
// [R17] Waker: semaphore free before waking.
// [R18] Each core has distinct management base.
// [R19] Mapped identifier sits in top byte.
// [R20] Later reinit never repeats the election.
// [R21] Bus-not-ready pin synchronised and filtered.
`timescale 1ns/1ps
module mbre_core
    import mbre_pkg::*;
#(
    parameter int BUILTIN_SELF_TEST_CYCLES = 64,
    parameter int BNR_QUIET = 16,
    parameter logic [31:0] MGMT_ROOT = 32'h00030000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] ident_strap_i,
    input wire logic ext_topo_i,
    input wire logic new_rev_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic builtin_self_test_done_o,
    output logic leader_o,
    output logic fetch_go_o,
    output logic [31:0] fetch_addr_o,
    output logic halted_o,
    output logic int_take_o,
    output mbre_msg_e int_kind_o,
    output logic clk_stopped_o,
    mbre_link_if.core link
);
    typedef enum logic [3:0] {
        ST_CAPT = 4'h0,
        ST_BUILTIN_SELF_TEST = 4'h1,
        ST_BNR = 4'h2,
        ST_SPC = 4'h3,
        ST_CLAIM = 4'h4,
        ST_FINAL = 4'h5,
        ST_LEADER = 4'h6,
        ST_WAIT_SU = 4'h7,
        ST_SEM = 4'h8,
        ST_HALT = 4'h9
    } mbre_st_e;

    typedef struct packed {
        mbre_st_e st;
        logic ext;
        logic newrev;
        logic [31:0] ident;
        logic leader;
        logic [31:0] spurious_vector_reg;
        logic [31:0] errv;
        logic [31:0] cmd;
        logic [15:0] builtin_self_test;
        logic [15:0] quiet;
        logic [2:0] bnr;
        logic [31:0] fetch;
        logic fgo;
        logic [31:0] rdata;
        logic spc;
        logic claim;
        logic fin;
        logic sem;
        logic rel;
        logic inc;
        logic ocv;
        logic [31:0] ocw;
        logic take;
        mbre_msg_e tk;
        logic stopped;
        logic bdone, halt;
    } mbre_core_s;

    mbre_core_s q, d;
    logic in_reinit;
    logic in_su;
    logic elected;

    assign in_reinit = link.cmd_valid && link.cmd_word == CMD_REINIT; // see [R14]
    assign in_su = link.cmd_valid && link.cmd_word[31:8] == CMD_SU_HI; // see [R14]
    assign elected = q.st == ST_LEADER || q.st == ST_WAIT_SU || q.st == ST_SEM
        || q.st == ST_HALT;

    always_comb begin
        d = q;
        d.fgo = 1'b0;
        d.rel = 1'b0;
        d.inc = 1'b0;
        d.fin = 1'b0;
        d.ocv = 1'b0;
        d.take = 1'b0;
        d.tk = MSG_NONE;
        d.rdata = 32'h00000000;
        // The first stage only feeds the second; edges are seen on stages two and three.
        d.bnr = {q.bnr[1:0], link.bnr}; // see [R21]
        if (q.bnr[2] != q.bnr[1]) begin
            d.quiet = 16'h0000; // see [R21]
        end else if (q.quiet != 16'hffff) begin
            d.quiet = q.quiet + 16'h0001;
        end
        if (rd_i) begin
            case (addr_i)
                IDENT_OFF: d.rdata = q.ext ? q.ident : {q.ident[7:0], 24'h000000}; // see [R19]
                SVR_OFF: d.rdata = q.spurious_vector_reg;
                CMD_OFF: d.rdata = q.cmd;
                ERRV_OFF: d.rdata = q.errv;
                STAT_OFF: d.rdata = {24'h000000, q.st, q.newrev, q.ext, halted_o, q.leader};
                default: d.rdata = 32'h00000000;
            endcase
        end
        if (wr_i) begin
            case (addr_i)
                IDENT_OFF: begin
                    if (q.ext) begin
                        d.ident = wdata_i;
                    end else begin
                        d.ident = {24'h000000, wdata_i[IDENT_TOP +: 8]}; // see [R19]
                    end
                end
                SVR_OFF: d.spurious_vector_reg = wdata_i; // see [R12]
                ERRV_OFF: d.errv = wdata_i; // see [R13]
                CMD_OFF: begin
                    d.cmd = wdata_i;
                    // A disabled controller sends nothing.
                    if (q.spurious_vector_reg[SVR_EN_BIT] && (wdata_i == CMD_REINIT
                        || wdata_i[31:8] == CMD_SU_HI)) begin
                        d.ocv = 1'b1; // see [R12] see [R14]
                        d.ocw = wdata_i;
                    end
                end
                default: d = d;
            endcase
        end
        case (q.st)
            ST_CAPT: begin
                // Straps are caught after reset release, never under reset.
                d.ext = ext_topo_i; // see [R01]
                d.newrev = new_rev_i;
                d.ident = ext_topo_i ? ident_strap_i : {24'h000000, ident_strap_i[7:0]}; // see [R01]
                d.builtin_self_test = 16'h0000;
                d.st = ST_BUILTIN_SELF_TEST;
            end
            ST_BUILTIN_SELF_TEST: begin
                d.builtin_self_test = q.builtin_self_test + 16'h0001;
                if (q.builtin_self_test == 16'(BUILTIN_SELF_TEST_CYCLES - 1)) begin
                    d.quiet = 16'h0000;
                    d.st = q.newrev ? ST_BNR : ST_CLAIM; // see [R03]
                    d.claim = !q.newrev; // see [R07]
                end
            end
            ST_BNR: begin
                if (q.quiet >= 16'(BNR_QUIET)) begin
                    d.spc = 1'b1; // see [R04]
                    d.st = ST_SPC;
                end
            end
            ST_SPC: begin
                if (link.spc_ack) begin
                    d.spc = 1'b0;
                    d.leader = link.spc_won; // see [R05] see [R06]
                    d.fetch = RESET_VEC;
                    d.fgo = link.spc_won; // see [R05]
                    d.st = link.spc_won ? ST_LEADER : ST_WAIT_SU; // see [R06]
                end
            end
            ST_CLAIM: begin
                if (link.claim_ack) begin
                    d.claim = 1'b0;
                    d.leader = link.claim_won; // see [R07]
                    d.fin = link.claim_won; // see [R08]
                    d.st = link.claim_won ? ST_FINAL : ST_WAIT_SU; // see [R07]
                end
            end
            ST_FINAL: begin
                if (link.final_rx && q.leader) begin
                    d.fetch = RESET_VEC; // see [R08]
                    d.fgo = 1'b1;
                    d.st = ST_LEADER;
                end
            end
            ST_WAIT_SU: begin
                if (in_su) begin
                    d.fetch = {12'h000, link.cmd_word[7:0], 12'h000}; // see [R09]
                    d.fgo = 1'b1;
                    d.st = ST_SEM;
                end
            end
            ST_SEM: begin
                d.sem = 1'b1; // see [R10]
                if (link.sem_gnt) begin
                    d.sem = 1'b0;
                    d.inc = 1'b1; // see [R10]
                    d.rel = 1'b1;
                    d.st = ST_HALT;
                end
            end
            ST_HALT: begin
                if (link.evt_valid && link.evt_kind != MSG_FIXED) begin
                    d.take = 1'b1; // see [R11]
                    d.tk = link.evt_kind;
                end
            end
            default: d.st = q.st;
        endcase
        d.stopped = q.st == ST_HALT && link.stop_clk; // see [R11]
        // After election a reinit only consults the leader flag.
        if (elected && in_reinit) begin
            d.sem = 1'b0;
            d.fetch = RESET_VEC;
            d.fgo = q.leader; // see [R20]
            d.st = q.leader ? ST_LEADER : ST_WAIT_SU; // see [R20]
            if (q.st == ST_HALT) begin
                d.take = 1'b1; // see [R11]
                d.tk = MSG_REINIT;
            end
        end
        d.bdone = d.st != ST_CAPT && d.st != ST_BUILTIN_SELF_TEST;
        d.halt = d.st == ST_HALT;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{st: ST_CAPT, spurious_vector_reg: SVR_RST, errv: ERRV_RST, tk: MSG_NONE, default: '0}; // see [R12]
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign builtin_self_test_done_o = q.bdone;
    assign leader_o = q.leader;
    assign fetch_go_o = q.fgo;
    assign fetch_addr_o = q.fetch;
    assign halted_o = q.halt;
    assign int_take_o = q.take;
    assign int_kind_o = q.tk;
    assign clk_stopped_o = q.stopped;
    assign link.spc_req = q.spc;
    assign link.spc_prio = q.ident[7:0]; // see [R02]
    assign link.claim_req = q.claim;
    assign link.final_req = q.fin;
    assign link.sem_req = q.sem;
    assign link.sem_rel = q.rel;
    assign link.cnt_inc = q.inc;
    assign link.mgmt_base = MGMT_ROOT + {8'h00, q.ident[7:0], 16'h0000}; // see [R18]
    assign link.dev_cmd_valid = q.ocv;
    assign link.dev_cmd_word = q.ocw;
endmodule // mbre_core

// ===== hdl/mbre_waker.sv
// The waking peer and the shared bus as seen by one core: bus-not-ready
// toggling, arbitration answers, semaphore, count and the wake sequence.
// Assumes one core on the link; other peers are summed up by user inputs.
`timescale 1ns/1ps
module mbre_waker
    import mbre_pkg::*;
#(
    parameter int BNR_TOGGLE = 32,
    parameter logic [CNT_W-1:0] REINIT_WAIT = CNT_W'(REINIT_CYC),
    parameter logic [CNT_W-1:0] STARTUP_WAIT = CNT_W'(STARTUP_CYC),
    parameter logic [CNT_W-1:0] COUNT_WAIT = CNT_W'(COUNT_CYC),
    parameter logic [31:0] OWN_MGMT_BASE = 32'h00020000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] vector_i,
    input wire logic [7:0] peer_prio_i,
    input wire logic peer_claims_first_i,
    input wire logic evt_req_i,
    input wire mbre_msg_e evt_kind_i,
    input wire logic stop_clk_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] count_o,
    output logic none_found_o,
    output logic base_clash_o,
    output logic [31:0] dev_cmd_o,
    mbre_link_if.waker link
);
    typedef enum logic [2:0] {
        W_IDLE = 3'b000,
        W_REINIT = 3'b001,
        W_SU1 = 3'b010,
        W_SU2 = 3'b011,
        W_TIMER = 3'b100
    } mbre_wst_e;

    typedef struct packed {
        mbre_wst_e st;
        logic [15:0] tog;
        logic bnr;
        logic spc_ack;
        logic spc_won;
        logic claim_ack;
        logic claim_won;
        logic fin;
        logic cv;
        logic [31:0] cw;
        logic ev;
        mbre_msg_e ek;
        logic stop;
        logic [7:0] sem;
        logic gnt;
        logic [7:0] count;
        logic [7:0] vec;
        logic [CNT_W-1:0] wt;
        logic [CNT_W-1:0] tmr;
        logic done;
        logic none;
        logic clash;
        logic [31:0] dcmd;
        logic busy;
    } mbre_waker_s;

    mbre_waker_s q, d;

    always_comb begin
        d = q;
        d.spc_ack = 1'b0;
        d.claim_ack = 1'b0;
        d.fin = 1'b0;
        d.cv = 1'b0;
        d.ev = evt_req_i;
        d.ek = evt_req_i ? evt_kind_i : MSG_NONE;
        d.stop = stop_clk_i;
        d.gnt = 1'b0;
        d.done = 1'b0;
        // The pin toggles for a while after reset, then rests high.
        if (q.tog != 16'(BNR_TOGGLE)) begin
            d.tog = q.tog + 16'h0001;
            d.bnr = !q.bnr;
        end else begin
            d.bnr = 1'b1;
        end
        if (link.spc_req && !q.spc_ack) begin
            d.spc_ack = 1'b1;
            d.spc_won = link.spc_prio > peer_prio_i; // see [R05]
        end
        if (link.claim_req && !q.claim_ack) begin
            d.claim_ack = 1'b1;
            d.claim_won = !peer_claims_first_i; // see [R07]
        end
        d.fin = link.final_req; // see [R08]
        if (link.sem_req && !q.gnt && q.sem == SEM_FREE) begin
            d.gnt = 1'b1; // see [R10]
            d.sem = SEM_TAKEN;
        end
        if (link.sem_rel) begin
            d.sem = SEM_FREE;
        end
        if (link.cnt_inc) begin
            d.count = q.count + 8'h01; // see [R10]
        end
        if (link.dev_cmd_valid) begin
            d.dcmd = link.dev_cmd_word;
        end
        d.clash = link.mgmt_base == OWN_MGMT_BASE; // see [R18]
        if (q.tmr != '0) begin
            d.tmr = q.tmr - CNT_W'(1);
        end
        if (q.wt != '0) begin
            d.wt = q.wt - CNT_W'(1);
        end
        case (q.st)
            W_IDLE: begin
                if (start_i) begin
                    d.count = COUNT_INIT; // see [R16]
                    d.sem = SEM_FREE; // see [R17]
                    d.tmr = COUNT_WAIT; // see [R16]
                    d.vec = vector_i;
                    d.cv = 1'b1;
                    d.cw = CMD_REINIT; // see [R14]
                    d.wt = REINIT_WAIT; // see [R15]
                    d.st = W_REINIT;
                end
            end
            W_REINIT, W_SU1: begin
                if (q.wt == CNT_W'(1)) begin
                    d.cv = 1'b1;
                    d.cw = {CMD_SU_HI, q.vec}; // see [R14] see [R15]
                    d.wt = STARTUP_WAIT;
                    d.st = q.st == W_REINIT ? W_SU1 : W_SU2;
                end
            end
            W_SU2: begin
                if (q.wt == CNT_W'(1)) begin
                    d.st = W_TIMER; // see [R15]
                end
            end
            W_TIMER: begin
                if (q.tmr == '0) begin
                    d.done = 1'b1;
                    d.none = q.count == COUNT_INIT; // see [R16]
                    d.st = W_IDLE;
                end
            end
            default: d.st = W_IDLE;
        endcase
        // A start that meets a release in the same cycle leaves the semaphore free.
        if (q.st == W_IDLE && start_i && link.sem_rel) begin
            d.sem = SEM_FREE;
        end
        d.busy = d.st != W_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{st: W_IDLE, ek: MSG_NONE, sem: SEM_FREE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign busy_o = q.busy;
    assign done_o = q.done;
    assign count_o = q.count;
    assign none_found_o = q.none;
    assign base_clash_o = q.clash;
    assign dev_cmd_o = q.dcmd;
    assign link.bnr = q.bnr;
    assign link.spc_ack = q.spc_ack;
    assign link.spc_won = q.spc_won;
    assign link.claim_ack = q.claim_ack;
    assign link.claim_won = q.claim_won;
    assign link.final_rx = q.fin;
    assign link.cmd_valid = q.cv;
    assign link.cmd_word = q.cw;
    assign link.evt_valid = q.ev;
    assign link.evt_kind = q.ek;
    assign link.stop_clk = q.stop;
    assign link.sem_gnt = q.gnt;
endmodule // mbre_waker

// ===== testbench/mbre_link_sva.sv
// Concurrent checks on the link between one core and its waker.
// Assumes both ends share clk_i and the synchronous reset rst_i.
`timescale 1ns/1ps
module mbre_link_sva
    import mbre_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bnr,
    input wire logic spc_req,
    input wire logic spc_ack,
    input wire logic claim_req,
    input wire logic claim_ack,
    input wire logic final_req,
    input wire logic final_rx,
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_word,
    input wire logic sem_req,
    input wire logic sem_gnt,
    input wire logic cnt_inc,
    input wire logic [31:0] mgmt_base,
    input wire logic dev_cmd_valid,
    input wire logic [31:0] dev_cmd_word
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence reinit_s;
        cmd_valid && cmd_word == CMD_REINIT;
    endsequence
    sequence startup_s;
        cmd_valid && cmd_word[31:8] == CMD_SU_HI;
    endsequence
    // The spacing figures match the shortened waits the bench gives the waker.
    wake_order_a: assert property (reinit_s |-> ##50 startup_s ##10 startup_s)
        else $error("wake sequence spacing wrong");
    spc_quiet_a: assert property ($rose(spc_req) |->
        bnr && $past(bnr) && $past(bnr, 4))
        else $error("special cycle tried while pin toggling");
    spc_ack_a: assert property ($rose(spc_req) |=> spc_ack)
        else $error("special cycle not answered");
    spc_drop_a: assert property (spc_ack |=> !spc_req)
        else $error("special cycle request held after answer");
    claim_ack_a: assert property ($rose(claim_req) |=> claim_ack)
        else $error("claim not answered");
    final_rx_a: assert property (final_req |=> final_rx)
        else $error("final message not received");
    sem_order_a: assert property (sem_gnt |-> $past(sem_req))
        else $error("semaphore granted without request");
    count_in_a: assert property (sem_gnt |-> ##[1:4] cnt_inc)
        else $error("count not raised after semaphore");
    dev_cmd_a: assert property (dev_cmd_valid |->
        dev_cmd_word == CMD_REINIT || dev_cmd_word[31:8] == CMD_SU_HI)
        else $error("bad command word broadcast");
    mgmt_base_a: assert property (mgmt_base != 32'h00020000)
        else $error("management base clashes with waker");
endmodule // mbre_link_sva

// ===== testbench/testbench.sv
// Self-checking bench: one core and one waker joined by the link.
// Assumes shortened counts so each wake sequence fits in a short run.
`timescale 1ns/1ps
module testbench;
    import mbre_pkg::*;
    logic clk_i, rst_i, ext_topo_i, new_rev_i, wr_i, rd_i, start_i;
    logic peer_claims_first_i, evt_req_i, stop_clk_i, builtin_self_test_done_o, leader_o;
    logic fetch_go_o, halted_o, int_take_o, clk_stopped_o, busy_o, done_o;
    logic none_found_o, base_clash_o;
    logic [31:0] ident_strap_i, addr_i, wdata_i, rdata_o, fetch_addr_o, dev_cmd_o;
    logic [7:0] vector_i, peer_prio_i, count_o;
    mbre_msg_e evt_kind_i, int_kind_o;
    int failures, check_count;
    mbre_link_if link();
    mbre_core #(.BUILTIN_SELF_TEST_CYCLES(8), .BNR_QUIET(4)) u_mbre_core (.clk_i(clk_i), .rst_i(rst_i),
        .ident_strap_i(ident_strap_i), .ext_topo_i(ext_topo_i), .new_rev_i(new_rev_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .builtin_self_test_done_o(builtin_self_test_done_o), .leader_o(leader_o), .fetch_go_o(fetch_go_o),
        .fetch_addr_o(fetch_addr_o), .halted_o(halted_o), .int_take_o(int_take_o),
        .int_kind_o(int_kind_o), .clk_stopped_o(clk_stopped_o), .link(link));
    mbre_waker #(.REINIT_WAIT(24'h32), .STARTUP_WAIT(24'h0a),
        .COUNT_WAIT(24'hc8)) u_mbre_waker (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
        .vector_i(vector_i), .peer_prio_i(peer_prio_i),
        .peer_claims_first_i(peer_claims_first_i), .evt_req_i(evt_req_i),
        .evt_kind_i(evt_kind_i), .stop_clk_i(stop_clk_i), .busy_o(busy_o), .done_o(done_o),
        .count_o(count_o), .none_found_o(none_found_o), .base_clash_o(base_clash_o),
        .dev_cmd_o(dev_cmd_o), .link(link));
    mbre_link_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .bnr(link.bnr),
        .spc_req(link.spc_req), .spc_ack(link.spc_ack), .claim_req(link.claim_req),
        .claim_ack(link.claim_ack), .final_req(link.final_req), .final_rx(link.final_rx),
        .cmd_valid(link.cmd_valid), .cmd_word(link.cmd_word), .sem_req(link.sem_req),
        .sem_gnt(link.sem_gnt), .cnt_inc(link.cnt_inc), .mgmt_base(link.mgmt_base),
        .dev_cmd_valid(link.dev_cmd_valid), .dev_cmd_word(link.dev_cmd_word));

    task automatic wrap_up;
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic elect(input logic nr, input logic ext, input logic [7:0] prio,
        input logic first, input logic lead);
        logic [31:0] d;
        @(posedge clk_i);
        rst_i <= 1'b1;
        new_rev_i <= nr;
        ext_topo_i <= ext;
        peer_prio_i <= prio;
        peer_claims_first_i <= first;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (80) @(posedge clk_i);
        #1;
        chk(builtin_self_test_done_o, 1'b1);
        chk(leader_o, lead);
        if (lead)
            chk(fetch_addr_o, RESET_VEC);
        chk(base_clash_o, 1'b0);
        rd(IDENT_OFF, d);
        chk(d, ext ? ident_strap_i : {ident_strap_i[7:0], 24'h000000});
    endtask

    task automatic regs;
        logic [31:0] d;
        rd(SVR_OFF, d);
        chk(d, SVR_RST);
        wr(SVR_OFF, 32'h00000100);
        rd(SVR_OFF, d);
        chk(d, 32'h00000100);
        wr(ERRV_OFF, 32'h000000ab);
        rd(ERRV_OFF, d);
        chk(d, 32'h000000ab);
        rd(32'hfee00040, d);
        chk(d, 32'h00000000);
        wr(CMD_OFF, 32'h000c46bd);
        repeat (4) @(posedge clk_i);
        #1;
        chk(dev_cmd_o, 32'h000c46bd);
        wr(CMD_OFF, 32'h12345678);
        repeat (4) @(posedge clk_i);
        #1;
        chk(dev_cmd_o, 32'h000c46bd);
    endtask

    task automatic wake(input logic lead);
        int i;
        @(posedge clk_i);
        start_i <= 1'b1;
        vector_i <= 8'hbd;
        @(posedge clk_i);
        start_i <= 1'b0;
        if (!lead) begin
            for (i = 0; i < 100 && fetch_go_o !== 1'b1; i++) begin
                @(posedge clk_i);
                #1;
            end
            chk(fetch_addr_o, 32'h000bd000);
        end
        for (i = 0; i < 400 && done_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(done_o, 1'b1);
        chk(count_o, lead ? 8'h01 : 8'h02);
        chk(none_found_o, lead);
        chk(leader_o, lead);
        chk(halted_o, !lead);
    endtask

    task automatic events;
        mbre_msg_e k[4] = '{MSG_NMI, MSG_SMI, MSG_SNOOP, MSG_FIXED};
        int i;
        int j;
        logic hit;
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            evt_req_i <= 1'b1;
            evt_kind_i <= k[i];
            @(posedge clk_i);
            evt_req_i <= 1'b0;
            hit = 1'b0;
            for (j = 0; j < 4; j++) begin
                @(posedge clk_i);
                #1;
                if (int_take_o === 1'b1 && int_kind_o === k[i])
                    hit = 1'b1;
            end
            chk(hit, k[i] != MSG_FIXED);
        end
        @(posedge clk_i);
        stop_clk_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        chk(clk_stopped_o, 1'b1);
        @(posedge clk_i);
        stop_clk_i <= 1'b0;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        {rst_i, ext_topo_i, new_rev_i, wr_i, rd_i, start_i} = 6'h20;
        {peer_claims_first_i, evt_req_i, stop_clk_i} = 3'h0;
        ident_strap_i = 32'h12345640;
        addr_i = 32'h00000000;
        wdata_i = 32'h00000000;
        vector_i = 8'h00;
        peer_prio_i = 8'h00;
        evt_kind_i = MSG_NONE;
        failures = 0;
        check_count = 0;
        elect(1'b1, 1'b1, 8'h10, 1'b0, 1'b1);
        regs();
        wake(1'b1);
        elect(1'b1, 1'b0, 8'hf0, 1'b0, 1'b0);
        regs();
        wake(1'b0);
        events();
        elect(1'b0, 1'b1, 8'h10, 1'b0, 1'b1);
        elect(1'b0, 1'b0, 8'h10, 1'b1, 1'b0);
        wrap_up();
    end

    // The whole run needs about 850 cycles; a hang is cut off well beyond.
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        wrap_up();
    end
endmodule // testbench
